// ### hdl/sel_pkg.sv
// constants for the secondary error log register bank
package sel_pkg;
    localparam int SEL_ADDR_W = 12;
    localparam logic [11:0] SEL_OFF_HDR0 = 12'h11c;
    localparam logic [11:0] SEL_OFF_HDR1 = 12'h120;
    localparam logic [11:0] SEL_OFF_HDR2 = 12'h124;
    localparam logic [11:0] SEL_OFF_HDR3 = 12'h128;
    localparam logic [11:0] SEL_OFF_FLAGS = 12'h12c;
    localparam logic [11:0] SEL_OFF_SEVR = 12'h134;
    localparam logic [11:0] SEL_OFF_FIRST = 12'h138;
    localparam int SEL_BIT_SYS_ERR = 12;
    localparam int SEL_BIT_PAR_SIG = 11;
    localparam int SEL_BIT_DISCARD = 10;
    localparam int SEL_BIT_ADDR_PAR = 9;
    localparam int SEL_BIT_DATA_PAR = 7;
    localparam int SEL_BIT_MABORT = 3;
    localparam int SEL_BIT_TABORT = 2;
    // flag bits that exist; every other status bit reads zero
    localparam logic [31:0] SEL_FLAGS_LIVE = 32'h0000_1e8c;
    // severity bits software may write (bit 0 is read-only)
    localparam logic [31:0] SEL_SEVR_WMASK = 32'h0000_3fee;
    localparam logic [31:0] SEL_SEVR_RST = 32'h0000_1340;
    localparam logic [31:0] SEL_HDR_RST = 32'h0000_0000;
    localparam logic [31:0] SEL_FLAGS_RST = 32'h0000_0000;
    localparam logic [4:0] SEL_FIRST_RST = 5'h00;
    localparam int SEL_NUM_EVT = 7;
endpackage

// ### hdl/sel_evt_if.sv
// event bundle between the bank and its flag logic
`timescale 1ns/10ps
`default_nettype none
interface sel_evt_if;
    logic [31:0] evt_vec;
    logic [31:0] clr_vec;
    logic [31:0] flags;
    logic any_new;
    logic [4:0] first_pos;
    modport bank (output evt_vec, output clr_vec, input flags, input any_new, input first_pos);
    modport flag (input evt_vec, input clr_vec, output flags, output any_new, output first_pos);
endinterface
`default_nettype wire

// ### hdl/sel_flag_bits.sv
// sticky write-one-to-clear flags with first-error pointer
`timescale 1ns/10ps
`default_nettype none
module sel_flag_bits
    import sel_pkg::*;
(
    // clock and error-log reset
    input wire logic sys_clk_i,
    input wire logic log_rst_i,
    // events and clears
    sel_evt_if.flag ev
);
    logic [31:0] flags_reg;
    logic [31:0] flags_next;
    logic [4:0] first_reg;
    logic [4:0] first_next;
    logic [31:0] live_evt;
    logic [4:0] low_pos;

    assign live_evt = ev.evt_vec & SEL_FLAGS_LIVE;
    // set wins over a same-cycle clear
    assign flags_next = ((flags_reg & ~ev.clr_vec) | live_evt) & SEL_FLAGS_LIVE;

    // lowest set event position if several fire at once
    always_comb begin
        low_pos = 5'h00;
        for (int i = 31; i >= 0; i--) begin
            if (live_evt[i]) begin
                low_pos = 5'(i);
            end
        end
    end
    // pointer latches only when no flag was pending
    assign first_next = (live_evt != 32'h0 && flags_reg == 32'h0) ? low_pos : first_reg;

    always_ff @(posedge sys_clk_i) begin
        if (log_rst_i) begin
            flags_reg <= SEL_FLAGS_RST;
            first_reg <= SEL_FIRST_RST;
        end else begin
            flags_reg <= flags_next;
            first_reg <= first_next;
        end
    end

    assign ev.flags = flags_reg;
    assign ev.any_new = |live_evt;
    assign ev.first_pos = first_reg;
endmodule
`default_nettype wire

// ### hdl/sel_hdr_log.sv
// four-word packet header capture
`timescale 1ns/10ps
`default_nettype none
module sel_hdr_log
    import sel_pkg::*;
#(
    parameter int WORDS = 4
) (
    // clock and error-log reset
    input wire logic sys_clk_i,
    input wire logic log_rst_i,
    // capture
    input wire logic cap_i,
    input wire logic [32*WORDS-1:0] hdr_i,
    // stored words
    output logic [32*WORDS-1:0] hdr_o
);
    // the offsets and the read mux only know a four-word log
    if (WORDS != 4) begin : g_bad_words
        $error("header log needs four words");
    end
    logic [31:0] word_reg [WORDS];
    genvar g;
    generate
        for (g = 0; g < WORDS; g++) begin : g_word
            always_ff @(posedge sys_clk_i) begin
                if (log_rst_i) begin
                    word_reg[g] <= SEL_HDR_RST;
                end else if (cap_i) begin
                    word_reg[g] <= hdr_i[32*g +: 32];
                end
            end
            assign hdr_o[32*g +: 32] = word_reg[g];
        end
    endgenerate
endmodule
`default_nettype wire

// ### hdl/sel_regs.sv
// secondary error log register bank of the bridge
// Function
// - latest error overwrites the header log with its full packet header.
// - header log is four words at 0x11c..0x128, first word lowest.
// - earliest transmitted byte sits in each word's lowest byte.
// - header log clears only on link, global or power-on reset.
// - software clears status flags only by writing one; zero leaves them.
// - bit 12 sets when system error seen on secondary bus.
// - bit 11 sets when parity error signal seen on secondary bus.
// - bit 10 sets on discard timer expiry of secondary delayed transaction.
// - bit 9 sets on address-phase parity error of upstream transaction.
// - bit 7 sets on upstream write data parity or read-forward parity signal.
// - bit 3 sets when our initiated transaction gets master abort.
// - bit 2 sets when our initiated transaction gets target abort.
// - extended-bus-only bits 13,8,6,5,1,0 read zero, not writable.
// - reserved bits 31:14 and 4 read zero.
// - flags also clear on link, global or power-on reset.
// - severity bit one reports fatal, zero reports nonfatal.
// - severity resets to 0x1340.
// - five-bit pointer holds position of first detected error.
`timescale 1ns/10ps
`default_nettype none
module sel_regs
    import sel_pkg::*;
(
    // clock and resets
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic link_reset_n_i,
    input wire logic global_reset_n_i,
    // configuration access
    input wire logic cfg_wr_i,
    input wire logic cfg_rd_i,
    input wire logic [sel_pkg::SEL_ADDR_W-1:0] cfg_addr_i,
    input wire logic [31:0] cfg_wdata_i,
    output logic [31:0] cfg_rdata_o,
    output logic cfg_rvalid_o,
    // secondary bus pins
    input wire logic sec_serr_n_i,
    input wire logic sec_perr_n_i,
    // internal error events
    input wire logic discard_expired_i,
    input wire logic addr_parity_err_i,
    input wire logic wr_data_parity_err_i,
    input wire logic rd_fwd_active_i,
    input wire logic master_abort_i,
    input wire logic target_abort_i,
    // header of the erring packet, byte 0 earliest
    input wire logic hdr_valid_i,
    input wire logic [127:0] hdr_bytes_i,
    // error message request
    output logic err_msg_o,
    output logic err_fatal_o
);
    import sel_pkg::*;

    sel_evt_if ev ();

    // pins from the secondary bus go through two flops first
    logic [1:0] serr_sync_reg;
    logic [1:0] perr_sync_reg;
    logic link_rst_sync_reg;
    logic link_rst_meta_reg;
    logic glob_rst_meta_reg;
    logic glob_rst_sync_reg;
    logic log_rst;
    logic serr_seen;
    logic perr_seen;

    always_ff @(posedge sys_clk_i) begin
        serr_sync_reg <= {serr_sync_reg[0], ~sec_serr_n_i};
        perr_sync_reg <= {perr_sync_reg[0], ~sec_perr_n_i};
        link_rst_meta_reg <= ~link_reset_n_i;
        link_rst_sync_reg <= link_rst_meta_reg;
        glob_rst_meta_reg <= ~global_reset_n_i;
        glob_rst_sync_reg <= glob_rst_meta_reg;
    end

    // sys_rst_i stands for the internal power-on reset
    assign log_rst = sys_rst_i | link_rst_sync_reg | glob_rst_sync_reg;
    assign serr_seen = serr_sync_reg[1];
    assign perr_seen = perr_sync_reg[1];

    // event vector by status bit position
    logic [31:0] evt;
    always_comb begin
        evt = 32'h0;
        evt[SEL_BIT_SYS_ERR] = serr_seen;
        evt[SEL_BIT_PAR_SIG] = perr_seen;
        evt[SEL_BIT_DISCARD] = discard_expired_i;
        evt[SEL_BIT_ADDR_PAR] = addr_parity_err_i;
        // read forwarding parity uses the synchronised signal
        evt[SEL_BIT_DATA_PAR] = wr_data_parity_err_i | (rd_fwd_active_i & perr_seen);
        evt[SEL_BIT_MABORT] = master_abort_i;
        evt[SEL_BIT_TABORT] = target_abort_i;
    end

    // address decode
    logic hit_h0;
    logic hit_h1;
    logic hit_h2;
    logic hit_h3;
    logic hit_flags;
    logic hit_sevr;
    logic hit_first;
    assign hit_h0 = (cfg_addr_i == SEL_OFF_HDR0);
    assign hit_h1 = (cfg_addr_i == SEL_OFF_HDR1);
    assign hit_h2 = (cfg_addr_i == SEL_OFF_HDR2);
    assign hit_h3 = (cfg_addr_i == SEL_OFF_HDR3);
    assign hit_flags = (cfg_addr_i == SEL_OFF_FLAGS);
    assign hit_sevr = (cfg_addr_i == SEL_OFF_SEVR);
    assign hit_first = (cfg_addr_i == SEL_OFF_FIRST);

    assign ev.evt_vec = evt;
    assign ev.clr_vec = (cfg_wr_i && hit_flags) ? cfg_wdata_i : 32'h0;

    sel_flag_bits u_flags (
        .sys_clk_i(sys_clk_i),
        .log_rst_i(log_rst),
        .ev(ev)
    );

    // capture header on any live event while hdr_valid_i is high; newest error wins
    logic [127:0] hdr_q;
    sel_hdr_log #(.WORDS(4)) u_hdr (
        .sys_clk_i(sys_clk_i),
        .log_rst_i(log_rst),
        .cap_i(ev.any_new & hdr_valid_i),
        .hdr_i(hdr_bytes_i),
        .hdr_o(hdr_q)
    );

    // severity register
    logic [31:0] sevr_reg;
    logic [31:0] sevr_next;
    assign sevr_next = (cfg_wr_i && hit_sevr) ? (cfg_wdata_i & SEL_SEVR_WMASK) : sevr_reg;
    always_ff @(posedge sys_clk_i) begin
        if (log_rst) begin
            sevr_reg <= SEL_SEVR_RST;
        end else begin
            sevr_reg <= sevr_next;
        end
    end

    // message request: fatal if any new event has its severity bit set
    logic [31:0] new_live;
    logic msg_reg;
    logic fatal_reg;
    assign new_live = evt & SEL_FLAGS_LIVE;
    always_ff @(posedge sys_clk_i) begin
        if (log_rst) begin
            msg_reg <= 1'b0;
            fatal_reg <= 1'b0;
        end else begin
            msg_reg <= |new_live;
            fatal_reg <= |(new_live & sevr_reg);
        end
    end
    assign err_msg_o = msg_reg;
    assign err_fatal_o = fatal_reg;

    // read mux, registered one cycle after the request
    logic [31:0] rd_mux;
    assign rd_mux = hit_h0 ? hdr_q[31:0] :
                    hit_h1 ? hdr_q[63:32] :
                    hit_h2 ? hdr_q[95:64] :
                    hit_h3 ? hdr_q[127:96] :
                    hit_flags ? (ev.flags & SEL_FLAGS_LIVE) :
                    hit_sevr ? sevr_reg :
                    hit_first ? {27'h0, ev.first_pos} : 32'h0;
    logic [31:0] rdata_reg;
    logic rvalid_reg;
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            rdata_reg <= 32'h0;
            rvalid_reg <= 1'b0;
        end else begin
            rdata_reg <= cfg_rd_i ? rd_mux : rdata_reg;
            rvalid_reg <= cfg_rd_i;
        end
    end
    assign cfg_rdata_o = rdata_reg;
    assign cfg_rvalid_o = rvalid_reg;
endmodule
`default_nettype wire

// ### test/sel_regs_monitor.sv
// concurrent checks on the secondary error log register bank ports
`timescale 1ns/10ps
`default_nettype none
module sel_regs_monitor
    import sel_pkg::*;
(
    // clock, reset and access
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic cfg_rd_i,
    input wire logic [sel_pkg::SEL_ADDR_W-1:0] cfg_addr_i,
    input wire logic [31:0] cfg_rdata_o,
    input wire logic cfg_rvalid_o,
    // events and report
    input wire logic discard_expired_i,
    input wire logic addr_parity_err_i,
    input wire logic wr_data_parity_err_i,
    input wire logic master_abort_i,
    input wire logic target_abort_i,
    input wire logic err_msg_o,
    input wire logic err_fatal_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    chk_read_answered: assert property (cfg_rd_i |=> cfg_rvalid_o)
        else $error("read not answered");
    chk_valid_caused: assert property (cfg_rvalid_o |-> $past(cfg_rd_i))
        else $error("read valid without read");
    chk_rdata_held: assert property (!cfg_rd_i |=> $stable(cfg_rdata_o))
        else $error("read data moved without read");
    chk_flags_dead_zero: assert property (cfg_rd_i && cfg_addr_i == SEL_OFF_FLAGS |=>
        (cfg_rdata_o & ~SEL_FLAGS_LIVE) == 32'h0) else $error("dead flag bit read one");
    chk_sevr_rsvd_zero: assert property (cfg_rd_i && cfg_addr_i == SEL_OFF_SEVR |=>
        cfg_rdata_o[31:14] == 18'h0 && !cfg_rdata_o[4] && !cfg_rdata_o[0])
        else $error("reserved severity bit read one");
    chk_mabort_msg: assert property (master_abort_i |=> err_msg_o)
        else $error("master abort not reported");
    chk_tabort_msg: assert property (target_abort_i |=> err_msg_o)
        else $error("target abort not reported");
    chk_discard_msg: assert property (discard_expired_i |=> err_msg_o)
        else $error("discard expiry not reported");
    chk_addr_par_msg: assert property (addr_parity_err_i |=> err_msg_o)
        else $error("address parity not reported");
    chk_data_par_msg: assert property (wr_data_parity_err_i |=> err_msg_o)
        else $error("data parity not reported");
    chk_fatal_with_msg: assert property (err_fatal_o |-> err_msg_o)
        else $error("fatal without message");
    cover property (err_msg_o && err_fatal_o);
    cover property (err_msg_o && !err_fatal_o);
    cover property (cfg_rd_i && cfg_addr_i == SEL_OFF_HDR3);
endmodule
bind sel_regs sel_regs_monitor u_mon (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .cfg_rd_i(cfg_rd_i), .cfg_addr_i(cfg_addr_i), .cfg_rdata_o(cfg_rdata_o),
    .cfg_rvalid_o(cfg_rvalid_o), .discard_expired_i(discard_expired_i),
    .addr_parity_err_i(addr_parity_err_i), .wr_data_parity_err_i(wr_data_parity_err_i),
    .master_abort_i(master_abort_i), .target_abort_i(target_abort_i),
    .err_msg_o(err_msg_o), .err_fatal_o(err_fatal_o));
`default_nettype wire

// ### test/tb_sel_regs.sv
// self-checking bench for the secondary error log register bank
`timescale 1ns/10ps
`default_nettype none
module tb_sel_regs;
    import sel_pkg::*;
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic link_n = 1'b1;
    logic glob_n = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic rvalid, msg, fatal;
    logic serr_n = 1'b1;
    logic perr_n = 1'b1;
    logic fwd = 1'b0;
    logic hv = 1'b0;
    logic [4:0] ev = 5'h00;
    logic [127:0] hdr = 128'h0;
    int fails = 0;
    int cmp_count = 0;
    // flag bit driven by each entry of ev
    int bitpos[5] = '{3, 2, 10, 9, 7};
    sel_regs u_dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .link_reset_n_i(link_n),
        .global_reset_n_i(glob_n), .cfg_wr_i(wr), .cfg_rd_i(rd), .cfg_addr_i(addr),
        .cfg_wdata_i(wdata), .cfg_rdata_o(rdata), .cfg_rvalid_o(rvalid),
        .sec_serr_n_i(serr_n), .sec_perr_n_i(perr_n), .discard_expired_i(ev[2]),
        .addr_parity_err_i(ev[3]), .wr_data_parity_err_i(ev[4]), .rd_fwd_active_i(fwd),
        .master_abort_i(ev[0]), .target_abort_i(ev[1]), .hdr_valid_i(hv),
        .hdr_bytes_i(hdr), .err_msg_o(msg), .err_fatal_o(fatal));
    initial forever #5 sys_clk_i = ~sys_clk_i;
    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    // all bus tasks start and end just after a rising edge;
    // one idle edge after each strobe so the next call never re-raises it at once
    task automatic cfg_wr(input logic [11:0] a, input logic [31:0] d);
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(posedge sys_clk_i);
        #1 wr = 1'b0;
        wait_cyc(1);
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        rd = 1'b1;
        addr = a;
        @(posedge sys_clk_i);
        #1 rd = 1'b0;
        chk("rvalid", {31'h0, rvalid}, 32'h1);
        chk($sformatf("rdata at %h", a), rdata, exp);
        wait_cyc(1);
    endtask
    task automatic pulse(input int i, input logic fat);
        ev[i] = 1'b1;
        @(posedge sys_clk_i);
        #1 ev = 5'h00;
        chk("err_msg", {31'h0, msg}, 32'h1);
        chk("err_fatal", {31'h0, fatal}, {31'h0, fat});
        wait_cyc(1);
        chk("err_msg idle", {31'h0, msg}, 32'h0);
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic t_reset();
        for (int w = 0; w < 4; w++) rd_chk(SEL_OFF_HDR0 + 12'(4 * w), SEL_HDR_RST);
        rd_chk(SEL_OFF_FLAGS, SEL_FLAGS_RST);
        rd_chk(SEL_OFF_SEVR, SEL_SEVR_RST);
        rd_chk(SEL_OFF_FIRST, {27'h0, SEL_FIRST_RST});
        rd_chk(12'h130, 32'h0);
    endtask
    task automatic t_events();
        for (int i = 0; i < 5; i++) begin
            pulse(i, SEL_SEVR_RST[bitpos[i]]);
            rd_chk(SEL_OFF_FLAGS, 32'h1 << bitpos[i]);
            rd_chk(SEL_OFF_FIRST, 32'(bitpos[i]));
            cfg_wr(SEL_OFF_FLAGS, 32'h0);
            rd_chk(SEL_OFF_FLAGS, 32'h1 << bitpos[i]);
            cfg_wr(SEL_OFF_FLAGS, 32'h1 << bitpos[i]);
            rd_chk(SEL_OFF_FLAGS, 32'h0);
        end
    endtask
    task automatic t_pins();
        serr_n = 1'b0;
        wait_cyc(3);
        serr_n = 1'b1;
        wait_cyc(3);
        rd_chk(SEL_OFF_FLAGS, 32'h1000);
        cfg_wr(SEL_OFF_FLAGS, 32'hffff_ffff);
        fwd = 1'b1;
        perr_n = 1'b0;
        wait_cyc(3);
        perr_n = 1'b1;
        wait_cyc(3);
        fwd = 1'b0;
        rd_chk(SEL_OFF_FLAGS, 32'h0880);
        cfg_wr(SEL_OFF_FLAGS, 32'hffff_ffff);
    endtask
    task automatic t_same();
        pulse(0, 1'b0);
        // event and clear of the same flag meet at one edge
        ev[0] = 1'b1;
        wr = 1'b1;
        addr = SEL_OFF_FLAGS;
        wdata = 32'h8;
        @(posedge sys_clk_i);
        #1 ev = 5'h00;
        wr = 1'b0;
        wait_cyc(1);
        rd_chk(SEL_OFF_FLAGS, 32'h8);
        cfg_wr(SEL_OFF_FLAGS, 32'h8);
        cfg_wr(SEL_OFF_SEVR, 32'hffff_ffff);
        rd_chk(SEL_OFF_SEVR, SEL_SEVR_WMASK);
        pulse(0, 1'b1);
    endtask
    task automatic t_hdr();
        logic [7:0] b;
        for (int r = 0; r < 2; r++) begin
            b = (r == 0) ? 8'h10 : 8'h80;
            for (int k = 0; k < 16; k++) hdr[8*k +: 8] = b + 8'(k);
            hv = 1'b1;
            pulse(1, 1'b1);
            for (int w = 0; w < 4; w++) rd_chk(SEL_OFF_HDR0 + 12'(4 * w),
                {b + 8'(4 * w + 3), b + 8'(4 * w + 2), b + 8'(4 * w + 1), b + 8'(4 * w)});
            // software writes must not disturb the log
            cfg_wr(SEL_OFF_HDR0, 32'h0);
            rd_chk(SEL_OFF_HDR0, {b + 8'h3, b + 8'h2, b + 8'h1, b});
        end
    endtask
    task automatic t_log_reset();
        for (int i = 0; i < 2; i++) begin
            if (i == 1) pulse(2, 1'b0);
            link_n = (i != 0);
            glob_n = (i == 0);
            wait_cyc(4);
            link_n = 1'b1;
            glob_n = 1'b1;
            wait_cyc(4);
            rd_chk(SEL_OFF_HDR0, SEL_HDR_RST);
            rd_chk(SEL_OFF_FLAGS, SEL_FLAGS_RST);
            rd_chk(SEL_OFF_SEVR, SEL_SEVR_RST);
        end
    endtask
    task automatic test_done();
        if (fails == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // whole run is about two hundred cycles; this is ample margin
    initial begin
        #200000;
        fails++;
        test_done();
    end
    initial begin
        wait_cyc(16);
        sys_rst_i = 1'b0;
        wait_cyc(1);
        t_reset();
        t_events();
        t_pins();
        t_same();
        t_hdr();
        t_log_reset();
        test_done();
    end
endmodule
`default_nettype wire
